// File: include/supply_pin_ctrl_defs.vh
// register map, reset values and timing counts for the supply pin controller
// assumes byte addresses on an APB bus with 32-bit data, one word per register
`ifndef SUPPLY_PIN_CTRL_DEFS_VH
`define SUPPLY_PIN_CTRL_DEFS_VH

// channel counts
`define SUPPLY_CHANNELS       12
`define MARGIN_CHANNELS       8
`define FAULT_LINES           3

// register byte offsets
`define OFF_CTRL              8'h00
`define OFF_PSEN_POLARITY     8'h04
`define OFF_PSEN_PUSH_PULL    8'h08
`define OFF_PSEN_GPO_MODE     8'h0c
`define OFF_PSEN_STATE        8'h10
`define OFF_MARGIN_ENABLE     8'h14
`define OFF_MARGIN_GPO_MODE   8'h18
`define OFF_MARGIN_GPO_VALUE  8'h1c
`define OFF_MARGIN_DUTY_BASE  8'h20
`define OFF_LINE_ASSERT_EN0   8'h40
`define OFF_LINE_ASSERT_EN1   8'h44
`define OFF_LINE_ASSERT_EN2   8'h48
`define OFF_LINE_SHUT_EN0     8'h4c
`define OFF_LINE_SHUT_EN1     8'h50
`define OFF_LINE_SHUT_EN2     8'h54
`define OFF_CHAN_FAULT        8'h58
`define OFF_IRQ_STATUS        8'h5c
`define OFF_IRQ_MASK          8'h60
`define OFF_LINE_STATE        8'h64
`define OFF_SHUT_CLEAR        8'h68

// control register fields
`define CTRL_RECALL_DONE_BIT  0
`define CTRL_MONITOR_BIT      1

// interrupt status fields: bits 2..0 line seen asserted, bit 3 a shutdown latched
`define IRQ_SHUTDOWN_BIT      3
`define IRQ_BITS              4

// line state fields: bits 2..0 line low, bits 14..3 latched shutdowns
`define LINE_STATE_SHUT_LSB   3

// reset values
`define RST_PSEN_POLARITY     12'hfff
`define RST_PSEN_PUSH_PULL    12'h000
`define RST_ZERO12            12'h000
`define RST_ZERO8             8'h00
`define RST_DUTY              64'h0000000000000000

// margin pulse timing: 255 steps per period, duty ff means always high
`define MARGIN_PRESCALE       8
`define MARGIN_PERIOD_STEPS   8'hff

`endif

// File: rtl/sync_2ff.v
// two flip-flop synchroniser for a bus of independent levels
// assumes each bit is a slow level; no multi-bit coherence is promised
`timescale 1ns/1ns

module sync_2ff #(
    parameter WIDTH = 3,
    parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b1}}
) (
    // clock and reset
    input  wire             pclk,
    input  wire             presetn,
    // levels
    input  wire [WIDTH-1:0] async_in,
    output reg  [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] meta;   // first stage, read only by the second

    // two stages; reset to the idle level of the lines
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta     <= RESET_VALUE;
            sync_out <= RESET_VALUE;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end

endmodule // sync_2ff

// File: rtl/margin_pulse_gen.v
// margin pulse generator: shared step counter, one duty compare per channel
// assumes duty values are held stable by the register file
`timescale 1ns/1ns
`include "supply_pin_ctrl_defs.vh"

module margin_pulse_gen #(
    parameter CHANNELS = `MARGIN_CHANNELS,
    parameter PRESCALE = `MARGIN_PRESCALE
) (
    // clock and reset
    input  wire                  pclk,
    input  wire                  presetn,
    // duty per channel, eight bits each
    input  wire [8*CHANNELS-1:0] duty,
    // pulse level per channel
    output reg  [CHANNELS-1:0]   pulse
);

    reg [15:0] div_cnt;     // prescaler count
    reg        step_en;     // one-cycle step enable
    reg [7:0]  step_cnt;    // position within the period

    // divider: the pulse rate is a slow enable, not a second clock
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt <= 16'h0000;
            step_en <= 1'b0;
        end else if (div_cnt == PRESCALE[15:0] - 16'h0001) begin
            div_cnt <= 16'h0000;
            step_en <= 1'b1;
        end else begin
            div_cnt <= div_cnt + 16'h0001;
            step_en <= 1'b0;
        end
    end

    // step counter wraps after 255 steps so duty ff never sees a low step
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            step_cnt <= 8'h00;
        end else if (step_en) begin
            if (step_cnt == `MARGIN_PERIOD_STEPS - 8'h01) begin
                step_cnt <= 8'h00;
            end else begin
                step_cnt <= step_cnt + 8'h01;
            end
        end
    end

    genvar i;
    generate
        for (i = 0; i < CHANNELS; i = i + 1) begin : g_cmp
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    pulse[i] <= 1'b0;
                end else begin
                    pulse[i] <= (duty[8*i+:8] == `MARGIN_PERIOD_STEPS) || (step_cnt < duty[8*i+:8]);
                end
            end
        end
    endgenerate

endmodule // margin_pulse_gen

// File: rtl/supply_pin_ctrl.v
// supply enable, margin pulse and shared fault line pin control with APB registers
// assumes channel fault flags come from monitoring logic on pclk; fault pins are async
//
// Functional notes
// - supply enable polarity selectable per channel
// - supply enable open-drain or push-pull
// - supply enable usable as general output
// - margin output high-impedance when margining disabled
// - full duty drives margin output always high
// - margin output usable as general output
// - three fault lines handled independently
// - per channel enables choose lines to assert
// - per channel enables shut down on line
// - devices share lines, observe and react
// - fault lines released throughout reset
// - lines pulled low from recall until monitoring
// - monitoring releases lines without enabled faults
// - pins high-impedance during power-up and reset
// - fault line is open-drain, active low
`timescale 1ns/1ns
`include "supply_pin_ctrl_defs.vh"

module supply_pin_ctrl #(
    parameter NSUP     = `SUPPLY_CHANNELS,
    parameter NMRG     = `MARGIN_CHANNELS,
    parameter PRESCALE = `MARGIN_PRESCALE
) (
    // clock and reset
    input  wire            pclk,
    input  wire            presetn,
    // apb slave
    input  wire            psel,
    input  wire            penable,
    input  wire            pwrite,
    input  wire [7:0]      paddr,
    input  wire [31:0]     pwdata,
    output reg  [31:0]     prdata,
    output reg             pready,
    output reg             pslverr,
    // channel faults from monitoring logic
    input  wire [NSUP-1:0] chan_fault,
    // supply enable pins
    output reg  [NSUP-1:0] supply_enable_out,
    output reg  [NSUP-1:0] supply_enable_oe,
    // margin pulse pins
    output reg  [NMRG-1:0] margin_pulse_out,
    output reg  [NMRG-1:0] margin_pulse_oe,
    // shared fault lines, open drain
    input  wire [2:0]      fault_line_in,
    output reg  [2:0]      fault_line_out,
    output reg  [2:0]      fault_line_oe,
    // interrupt
    output reg             irq
);

    // fault line phases, one-hot
    localparam [2:0] PH_RELEASE = 3'b001;   // lines left floating
    localparam [2:0] PH_HOLD    = 3'b010;   // recall done, lines held low
    localparam [2:0] PH_MONITOR = 3'b100;   // lines follow enabled faults

    // control and configuration registers
    reg              recall_done;       // stored configuration loaded
    reg              monitor_on;        // monitoring has started
    reg [NSUP-1:0]   psen_polarity;     // 1 = asserted high
    reg [NSUP-1:0]   psen_push_pull;    // 1 = drive both levels
    reg [NSUP-1:0]   psen_gpo_mode;     // 1 = general output
    reg [NSUP-1:0]   psen_state;        // enable request or output value
    reg [NMRG-1:0]   margin_enable;     // margining on per channel
    reg [NMRG-1:0]   margin_gpo_mode;   // 1 = general output
    reg [NMRG-1:0]   margin_gpo_value;  // level in general output mode
    reg [8*NMRG-1:0] margin_duty;       // duty per channel
    reg [3*NSUP-1:0] line_assert_en;    // channel drives line, line-major
    reg [3*NSUP-1:0] line_shut_en;      // channel shuts on line, line-major
    reg [NSUP-1:0]   shut;              // latched shutdowns
    reg [3:0]        irq_status;        // sticky events
    reg [3:0]        irq_mask;          // 1 = event reaches irq

    // fault line logic
    reg  [2:0]       phase;             // fault line phase
    reg  [2:0]       next_phase;
    reg  [2:0]       line_low_d;        // previous observed level
    wire [2:0]       line_level;        // synchronised pin levels
    wire [2:0]       line_low;          // observed asserted
    wire [2:0]       line_req;          // own enabled faults per line
    wire [NSUP-1:0]  shut_req;          // channels told to shut down
    wire [NMRG-1:0]  pulse;             // margin pulses
    wire [NSUP-1:0]  psen_active;       // enable asserted per channel
    wire [NSUP-1:0]  psen_level;        // pin level after polarity

    // apb decode
    wire             access;            // completing transfer
    wire             wr_en;
    wire             rd_en;
    wire             duty_sel;          // address in the duty block
    reg  [31:0]      next_prdata;
    reg              next_err;

    // pin inputs pass two flops; idle level of a released line is high
    sync_2ff #(
        .WIDTH       (3),
        .RESET_VALUE (3'b111)
    ) u_line_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (fault_line_in),
        .sync_out (line_level)
    );

    // margin pulse source
    margin_pulse_gen #(
        .CHANNELS (NMRG),
        .PRESCALE (PRESCALE)
    ) u_margin (
        .pclk    (pclk),
        .presetn (presetn),
        .duty    (margin_duty),
        .pulse   (pulse)
    );

    assign line_low = ~line_level;

    genvar k;
    genvar c;
    generate
        for (k = 0; k < 3; k = k + 1) begin : g_line
            assign line_req[k] = |(chan_fault & line_assert_en[k*NSUP+:NSUP]);
        end
        for (c = 0; c < NSUP; c = c + 1) begin : g_chan
            assign shut_req[c] = phase[2] & ((line_shut_en[c] & line_low[0]) |
                                             (line_shut_en[NSUP+c] & line_low[1]) |
                                             (line_shut_en[2*NSUP+c] & line_low[2]));
        end
    endgenerate

    // apb: no wait state, pready rises the cycle after setup
    assign access   = psel & penable & pready;
    assign wr_en    = access & pwrite;
    assign rd_en    = access & ~pwrite;
    assign duty_sel = (paddr[7:5] == 3'b001);

    // phase sequencing of the shared lines
    always @* begin
        next_phase = phase;
        case (phase)
            PH_RELEASE: begin
                if (recall_done) begin
                    next_phase = PH_HOLD;
                end
            end
            PH_HOLD: begin
                if (!recall_done) begin
                    next_phase = PH_RELEASE;
                end else if (monitor_on) begin
                    next_phase = PH_MONITOR;
                end
            end
            PH_MONITOR: begin
                // software stopping monitoring goes back to holding low
                if (!recall_done) begin
                    next_phase = PH_RELEASE;
                end else if (!monitor_on) begin
                    next_phase = PH_HOLD;
                end
            end
            default: begin
                next_phase = PH_RELEASE;
            end
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase      <= PH_RELEASE;
            line_low_d <= 3'b000;
        end else begin
            phase      <= next_phase;
            line_low_d <= line_low;
        end
    end

    // read mux and error answer, sampled during setup
    always @* begin
        next_prdata = 32'h00000000;
        next_err    = 1'b0;
        if (duty_sel) begin
            if (paddr[4:2] < NMRG) begin
                next_prdata[7:0] = margin_duty[8*paddr[4:2]+:8];
            end else begin
                next_err = 1'b1;
            end
        end else begin
            case (paddr)
                `OFF_CTRL: begin
                    next_prdata[`CTRL_RECALL_DONE_BIT] = recall_done;
                    next_prdata[`CTRL_MONITOR_BIT]     = monitor_on;
                end
                `OFF_PSEN_POLARITY:    next_prdata[NSUP-1:0] = psen_polarity;
                `OFF_PSEN_PUSH_PULL:   next_prdata[NSUP-1:0] = psen_push_pull;
                `OFF_PSEN_GPO_MODE:    next_prdata[NSUP-1:0] = psen_gpo_mode;
                `OFF_PSEN_STATE:       next_prdata[NSUP-1:0] = psen_state;
                `OFF_MARGIN_ENABLE:    next_prdata[NMRG-1:0] = margin_enable;
                `OFF_MARGIN_GPO_MODE:  next_prdata[NMRG-1:0] = margin_gpo_mode;
                `OFF_MARGIN_GPO_VALUE: next_prdata[NMRG-1:0] = margin_gpo_value;
                `OFF_LINE_ASSERT_EN0:  next_prdata[NSUP-1:0] = line_assert_en[0+:NSUP];
                `OFF_LINE_ASSERT_EN1:  next_prdata[NSUP-1:0] = line_assert_en[NSUP+:NSUP];
                `OFF_LINE_ASSERT_EN2:  next_prdata[NSUP-1:0] = line_assert_en[2*NSUP+:NSUP];
                `OFF_LINE_SHUT_EN0:    next_prdata[NSUP-1:0] = line_shut_en[0+:NSUP];
                `OFF_LINE_SHUT_EN1:    next_prdata[NSUP-1:0] = line_shut_en[NSUP+:NSUP];
                `OFF_LINE_SHUT_EN2:    next_prdata[NSUP-1:0] = line_shut_en[2*NSUP+:NSUP];
                `OFF_CHAN_FAULT:       next_prdata[NSUP-1:0] = chan_fault;
                `OFF_IRQ_STATUS:       next_prdata[3:0] = irq_status;
                `OFF_IRQ_MASK:         next_prdata[3:0] = irq_mask;
                `OFF_LINE_STATE: begin
                    next_prdata[2:0] = line_low;
                    next_prdata[`LINE_STATE_SHUT_LSB+:NSUP] = shut;
                end
                `OFF_SHUT_CLEAR:       next_prdata = 32'h00000000;
                default:               next_err = 1'b1;
            endcase
        end
    end

    // apb answer registers; pready drops after each completed access
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else if (psel && !penable) begin
            pready  <= 1'b1;
            pslverr <= next_err;
            prdata  <= pwrite ? 32'h00000000 : next_prdata;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // configuration writes; unmapped writes change nothing
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            recall_done      <= 1'b0;
            monitor_on       <= 1'b0;
            psen_polarity    <= `RST_PSEN_POLARITY;
            psen_push_pull   <= `RST_PSEN_PUSH_PULL;
            psen_gpo_mode    <= `RST_ZERO12;
            psen_state       <= `RST_ZERO12;
            margin_enable    <= `RST_ZERO8;
            margin_gpo_mode  <= `RST_ZERO8;
            margin_gpo_value <= `RST_ZERO8;
            margin_duty      <= `RST_DUTY;
            line_assert_en   <= {3*NSUP{1'b0}};
            line_shut_en     <= {3*NSUP{1'b0}};
            irq_mask         <= 4'h0;
        end else if (wr_en) begin
            if (duty_sel) begin
                if (paddr[4:2] < NMRG) begin
                    margin_duty[8*paddr[4:2]+:8] <= pwdata[7:0];
                end
            end else begin
                case (paddr)
                    `OFF_CTRL: begin
                        recall_done <= pwdata[`CTRL_RECALL_DONE_BIT];
                        monitor_on  <= pwdata[`CTRL_MONITOR_BIT];
                    end
                    `OFF_PSEN_POLARITY:    psen_polarity <= pwdata[NSUP-1:0];
                    `OFF_PSEN_PUSH_PULL:   psen_push_pull <= pwdata[NSUP-1:0];
                    `OFF_PSEN_GPO_MODE:    psen_gpo_mode <= pwdata[NSUP-1:0];
                    `OFF_PSEN_STATE:       psen_state <= pwdata[NSUP-1:0];
                    `OFF_MARGIN_ENABLE:    margin_enable <= pwdata[NMRG-1:0];
                    `OFF_MARGIN_GPO_MODE:  margin_gpo_mode <= pwdata[NMRG-1:0];
                    `OFF_MARGIN_GPO_VALUE: margin_gpo_value <= pwdata[NMRG-1:0];
                    `OFF_LINE_ASSERT_EN0:  line_assert_en[0+:NSUP] <= pwdata[NSUP-1:0];
                    `OFF_LINE_ASSERT_EN1:  line_assert_en[NSUP+:NSUP] <= pwdata[NSUP-1:0];
                    `OFF_LINE_ASSERT_EN2:  line_assert_en[2*NSUP+:NSUP] <= pwdata[NSUP-1:0];
                    `OFF_LINE_SHUT_EN0:    line_shut_en[0+:NSUP] <= pwdata[NSUP-1:0];
                    `OFF_LINE_SHUT_EN1:    line_shut_en[NSUP+:NSUP] <= pwdata[NSUP-1:0];
                    `OFF_LINE_SHUT_EN2:    line_shut_en[2*NSUP+:NSUP] <= pwdata[NSUP-1:0];
                    `OFF_IRQ_MASK:         irq_mask <= pwdata[3:0];
                    default: begin
                        // read-only or unmapped: nothing stored
                    end
                endcase
            end
        end
    end

    // react to any device's assertion
    // latched shutdown; a new request beats a same-cycle clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shut <= `RST_ZERO12;
        end else begin
            shut <= ((wr_en && paddr == `OFF_SHUT_CLEAR) ? (shut & ~pwdata[NSUP-1:0]) : shut) | shut_req;
        end
    end

    // sticky events; a read clears only the bits it reported, so an event
    // landing between setup and access survives; set wins over the clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= 4'h0;
            irq          <= 1'b0;
        end else begin
            irq_status <= ((rd_en && paddr == `OFF_IRQ_STATUS) ? (irq_status & ~prdata[3:0]) : irq_status) |
                          {|(shut_req & ~shut), line_low & ~line_low_d & {3{phase[2]}}};
            irq        <= |(irq_status & irq_mask);
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_line_out <= 3'b000;
            fault_line_oe  <= 3'b000;
        end else begin
            fault_line_out <= 3'b000;
            case (phase)
                PH_HOLD:    fault_line_oe <= 3'b111;
                PH_MONITOR: fault_line_oe <= line_req;
                default:    fault_line_oe <= 3'b000;
            endcase
        end
    end

    assign psen_active = (psen_state & psen_gpo_mode) | (psen_state & ~psen_gpo_mode & ~shut);
    assign psen_level  = ~(psen_active ^ psen_polarity);

    // pins float until recall
    // supply enable pins: level from polarity, enable from drive type
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            supply_enable_out <= {NSUP{1'b0}};
            supply_enable_oe  <= {NSUP{1'b0}};
        end else if (!recall_done) begin
            supply_enable_out <= {NSUP{1'b0}};
            supply_enable_oe  <= {NSUP{1'b0}};
        end else begin
            supply_enable_out <= psen_level & psen_push_pull;
            supply_enable_oe  <= psen_push_pull | ~psen_level;
        end
    end

    // margin pins: general output, pulse, or floating
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            margin_pulse_out <= {NMRG{1'b0}};
            margin_pulse_oe  <= {NMRG{1'b0}};
        end else if (!recall_done) begin
            margin_pulse_out <= {NMRG{1'b0}};
            margin_pulse_oe  <= {NMRG{1'b0}};
        end else begin
            margin_pulse_out <= (margin_gpo_mode & margin_gpo_value) | (~margin_gpo_mode & margin_enable & pulse);
            margin_pulse_oe  <= margin_gpo_mode | margin_enable;
        end
    end

endmodule // supply_pin_ctrl

// File: test/supply_pin_ctrl_sva.sv
// port-level assertions for the supply pin controller, bound to its top module
// assumes one pclk domain with presetn as asynchronous active-low reset
`timescale 1ns/1ns

module supply_pin_ctrl_sva #(
    parameter NSUP = 12,
    parameter NMRG = 8
) (
    // clock and reset
    input wire            pclk,
    input wire            presetn,
    // apb handshake
    input wire            psel,
    input wire            penable,
    input wire            pready,
    input wire            pslverr,
    // pins and interrupt
    input wire [NSUP-1:0] supply_enable_out,
    input wire [NSUP-1:0] supply_enable_oe,
    input wire [NMRG-1:0] margin_pulse_oe,
    input wire [2:0]      fault_line_out,
    input wire [2:0]      fault_line_oe,
    input wire            irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // setup cycle, then a single-cycle answer
    sequence setup_s; psel && !penable; endsequence
    sequence answer_s; pready ##1 !pready; endsequence
    apb_answer_a: assert property (setup_s |=> answer_s) else $error("ready not one cycle after setup");
    ready_cause_a: assert property ($rose(pready) |-> $past(psel && !penable)) else $error("ready without setup");
    err_ready_a: assert property (pslverr |-> pready) else $error("slave error without ready");
    // reset checks must not be disabled by the reset they watch
    reset_lines_off_a: assert property (disable iff (1'b0) !presetn |-> fault_line_oe == 3'b000)
        else $error("fault line pulled in reset");
    reset_pins_hiz_a: assert property (disable iff (1'b0) !presetn |-> !supply_enable_oe && !margin_pulse_oe && !irq)
        else $error("pin driven in reset");
    release_quiet_a: assert property ($rose(presetn) |-> (fault_line_oe == 3'b000 && !supply_enable_oe)[*2])
        else $error("pins driven right after reset");
    od_low_only_a: assert property ((supply_enable_out & ~supply_enable_oe) == '0)
        else $error("high output while not driving");
    fault_out_zero_a: assert property (fault_line_out == 3'b000)
        else $error("fault line driven high");
    refused_c: cover property (pslverr);
endmodule // supply_pin_ctrl_sva

bind supply_pin_ctrl supply_pin_ctrl_sva #(.NSUP(NSUP), .NMRG(NMRG)) chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .supply_enable_out(supply_enable_out),
    .supply_enable_oe(supply_enable_oe), .margin_pulse_oe(margin_pulse_oe), .fault_line_out(fault_line_out),
    .fault_line_oe(fault_line_oe), .irq(irq));

// File: test/fault_peer_model.sv
// peer managers and pull-ups on the three shared fault lines
// assumes the device only pulls a line low through its enable
`timescale 1ns/1ns

module fault_peer_model (
    // device side of the open-drain lines
    input  wire [2:0] fault_line_oe,
    input  wire [2:0] fault_line_out,
    // peers pulling a line low
    input  wire [2:0] peer_pull,
    // wire level seen by every device
    output wire [2:0] fault_line_in
);
    assign fault_line_in = ~peer_pull & (~fault_line_oe | fault_line_out);
endmodule // fault_peer_model

// File: test/tb.sv
// self-checking bench: apb master, fault line peer, pin checks per scenario
// assumes the design, its checker and the peer model are compiled first
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fails++; $display("[ERR] %s exp %h got %h", nm, e, g); end end

module tb;
    reg         pclk = 1'b0;
    reg         presetn = 1'b1;
    reg         psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    reg  [7:0]  paddr = 8'h00;
    reg  [31:0] pwdata = 32'h0, rdata;
    reg  [11:0] chan_fault = 12'h000;
    reg  [2:0]  peer_pull = 3'b000;
    reg         rerr;
    wire [31:0] prdata;
    wire        pready, pslverr, irq;
    wire [11:0] seo, seoe;
    wire [7:0]  mpo, mpoe;
    wire [2:0]  fli, flo, floe;
    integer     fails = 0, n_compared = 0;

    supply_pin_ctrl #(.PRESCALE(1)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .chan_fault(chan_fault), .supply_enable_out(seo), .supply_enable_oe(seoe), .margin_pulse_out(mpo),
        .margin_pulse_oe(mpoe), .fault_line_in(fli), .fault_line_out(flo), .fault_line_oe(floe), .irq(irq));
    fault_peer_model peer (.fault_line_oe(floe), .fault_line_out(flo), .peer_pull(peer_pull), .fault_line_in(fli));

    initial forever #10 pclk = ~pclk;

    task give_verdict;
        begin
            $display("compared %0d mismatches %0d", n_compared, fails);
            if (fails == 0 && n_compared > 0) $display("DONE - PASS");
            else $display("DONE - FAIL");
            $finish;
        end
    endtask

    task tick(input integer n);
        repeat (n) @(posedge pclk);
    endtask

    // one apb transfer; waits a bounded time for ready
    task apb(input bit wr, input [7:0] a, input [31:0] d);
        integer k;
        begin
            @(posedge pclk);
            psel <= 1'b1;
            pwrite <= wr;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            k = 0;
            do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 8);
            if (pready !== 1'b1) begin fails++; give_verdict; end
            rdata = prdata;
            rerr = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task s_reset;
        begin
            `CHK("fault oe", 3'b000, floe)
            `CHK("pin oe", 20'h00000, {seoe, mpoe})
            apb(0, 8'h04, 0);
            `CHK("polarity", 32'hfff, rdata)
        end
    endtask

    task s_lines;
        begin
            apb(1, 8'h44, 32'h4);
            apb(1, 8'h00, 32'h1);
            tick(4);
            `CHK("hold low", 3'b111, floe)
            apb(1, 8'h00, 32'h3);
            tick(4);
            `CHK("release", 3'b000, floe)
            chan_fault <= 12'h004;
            tick(3);
            `CHK("line1 only", 3'b010, floe)
            `CHK("wire level", 3'b101, fli)
            chan_fault <= 12'h000;
            tick(3);
            apb(0, 8'h5c, 0);
            `CHK("line event", 32'h2, rdata)
        end
    endtask

    task s_shutdown;
        begin
            apb(1, 8'h08, 32'h1);
            apb(1, 8'h10, 32'h1);
            apb(1, 8'h4c, 32'h1);
            apb(1, 8'h60, 32'hf);
            tick(3);
            `CHK("enable on", 2'b11, {seo[0], seoe[0]})
            peer_pull <= 3'b001;
            tick(6);
            `CHK("peer shutdown", 1'b0, seo[0])
            `CHK("irq raised", 1'b1, irq)
            peer_pull <= 3'b000;
            tick(4);
            apb(0, 8'h64, 0);
            `CHK("shut latched", 32'h8, rdata)
            apb(0, 8'h5c, 0);
            `CHK("events", 32'h9, rdata)
            apb(0, 8'h5c, 0);
            `CHK("read clears", 32'h0, rdata)
            `CHK("irq low", 1'b0, irq)
            apb(1, 8'h0c, 32'h1);
            tick(3);
            `CHK("gpo kept", 2'b11, {seo[0], seoe[0]})
        end
    endtask

    task s_enables;
        begin
            apb(1, 8'h04, 32'hffd);
            apb(1, 8'h10, 32'h3);
            tick(3);
            `CHK("active low od", 2'b01, {seo[1], seoe[1]})
            apb(1, 8'h10, 32'h1);
            tick(3);
            `CHK("od released", 2'b00, {seo[1], seoe[1]})
            apb(0, 8'h70, 0);
            `CHK("unmapped data", 32'h0, rdata)
            `CHK("unmapped err", 1'b1, rerr)
        end
    endtask

    task s_margin;
        integer k, bad;
        begin
            `CHK("margin hiz", 8'h00, mpoe)
            apb(1, 8'h20, 32'hff);
            apb(1, 8'h14, 32'h1);
            tick(3);
            bad = 0;
            for (k = 0; k < 300; k++) begin @(posedge pclk); if ({mpo[0], mpoe[0]} !== 2'b11) bad++; end
            `CHK("full duty", 0, bad)
            apb(1, 8'h14, 32'h0);
            apb(1, 8'h1c, 32'h2);
            apb(1, 8'h18, 32'h2);
            tick(3);
            `CHK("margin off", 1'b0, mpoe[0])
            `CHK("margin gpo", 2'b11, {mpo[1], mpoe[1]})
        end
    endtask

    initial begin
        // falling edge at time zero so every flop is reset before the first clock
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        s_reset;
        s_lines;
        s_shutdown;
        s_enables;
        s_margin;
        give_verdict;
    end
endmodule // tb
